// ===== logic/ilb_regs.sv
// Inband loopback code registers, detectors, generators and interrupt flags
`timescale 1ns/1ns
`default_nettype none
module ilb_regs #(
  parameter int DETECT_BITS = ilb_pkg::DETECT_BITS_DFLT
) (
  input  wire logic                       ref_clk_in,
  input  wire logic                       reset_in,
  input  wire logic [7:0]                 reg_addr_in,
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  input  wire logic [7:0]                 reg_wdata_in,
  output logic      [7:0]                 reg_rdata_out,
  input  wire logic [ilb_pkg::NUM_CH-1:0] rx_bit_valid_in,
  input  wire logic [ilb_pkg::NUM_CH-1:0] rx_data_in,
  input  wire logic [ilb_pkg::NUM_CH-1:0] tx_bit_valid_in,
  input  wire logic [ilb_pkg::NUM_CH-1:0] tx_data_in,
  output logic      [ilb_pkg::NUM_CH-1:0] tx_data_out,
  output logic      [ilb_pkg::NUM_CH-1:0] loop_active_out
);

  localparam int NCH = ilb_pkg::NUM_CH;

  generate
    if (NCH != 8) begin : g_bad
      $error("Register bank is built for eight channels");
    end
  endgenerate

  logic [7:0]     loop_config_r;
  logic [7:0]     activate_code_r;
  logic [7:0]     deactivate_code_r;
  logic [NCH-1:0] loop_irq_mask_r;
  logic [NCH-1:0] generator_code_choice_r;
  logic [NCH-1:0] generator_on_r;
  logic [NCH-1:0] loop_detect_state_r;
  logic [NCH-1:0] loop_detect_state_nxt;
  logic [NCH-1:0] loop_irq_flag_r;
  logic [NCH-1:0] act_hit;
  logic [NCH-1:0] deact_hit;
  logic [NCH-1:0] irq_set;
  logic           detector_global_enable;
  logic           auto_loop_enable;
  logic [3:0]     activate_len;
  logic [3:0]     deactivate_len;
  logic           status_read;

  assign detector_global_enable = loop_config_r[ilb_pkg::CFG_DET_EN_BIT];
  assign auto_loop_enable       = loop_config_r[ilb_pkg::CFG_AUTO_BIT];
  assign activate_len   = ilb_pkg::code_len(loop_config_r[ilb_pkg::CFG_ALEN_LSB +: 2]);
  assign deactivate_len = ilb_pkg::code_len(loop_config_r[ilb_pkg::CFG_DLEN_LSB +: 2]);
  assign status_read    = reg_rd_in && (reg_addr_in == ilb_pkg::OFS_RX_STATUS);

  // Register read decode
  function automatic logic [7:0] read_mux(input logic [7:0] addr);
    case (addr)
      ilb_pkg::OFS_CONFIG:     read_mux = loop_config_r;
      ilb_pkg::OFS_ACT_CODE:   read_mux = activate_code_r;
      ilb_pkg::OFS_DEACT_CODE: read_mux = deactivate_code_r;
      ilb_pkg::OFS_RX_STATUS:  read_mux = loop_detect_state_r;
      ilb_pkg::OFS_IRQ_MASK:   read_mux = loop_irq_mask_r;
      ilb_pkg::OFS_IRQ_STATUS: read_mux = loop_irq_flag_r;
      ilb_pkg::OFS_GEN_SELECT: read_mux = generator_code_choice_r;
      ilb_pkg::OFS_GEN_ENABLE: read_mux = generator_on_r;
      default:                 read_mux = ilb_pkg::READ_UNMAPPED;
    endcase
  endfunction

  // Writable registers
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      loop_config_r           <= ilb_pkg::RST_BYTE;
      activate_code_r         <= ilb_pkg::RST_BYTE;
      deactivate_code_r       <= ilb_pkg::RST_BYTE;
      loop_irq_mask_r         <= ilb_pkg::RST_BYTE;
      generator_code_choice_r <= ilb_pkg::RST_BYTE;
      generator_on_r          <= ilb_pkg::RST_BYTE;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        ilb_pkg::OFS_CONFIG:     loop_config_r           <= reg_wdata_in;
        ilb_pkg::OFS_ACT_CODE:   activate_code_r         <= reg_wdata_in;
        ilb_pkg::OFS_DEACT_CODE: deactivate_code_r       <= reg_wdata_in;
        ilb_pkg::OFS_IRQ_MASK:   loop_irq_mask_r         <= reg_wdata_in;
        ilb_pkg::OFS_GEN_SELECT: generator_code_choice_r <= reg_wdata_in;
        ilb_pkg::OFS_GEN_ENABLE: generator_on_r          <= reg_wdata_in;
        default: begin
        end
      endcase
    end
  end

  // Read data is captured on the read strobe and holds until the next read
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      reg_rdata_out <= ilb_pkg::RST_BYTE;
    end else if (reg_rd_in) begin
      reg_rdata_out <= read_mux(reg_addr_in);
    end
  end

  // Detectors, one per receive channel, sharing the global codes
  for (genvar ch = 0; ch < NCH; ch++) begin : g_det
    ilb_detector #(
      .DETECT_BITS (DETECT_BITS)
    ) u_det (
      .ref_clk_in    (ref_clk_in),
      .reset_in      (reset_in),
      .bit_valid_in  (rx_bit_valid_in[ch]),
      .bit_in        (rx_data_in[ch]),
      .det_enable_in (detector_global_enable),
      .act_code_in   (activate_code_r),
      .act_len_in    (activate_len),
      .deact_code_in (deactivate_code_r),
      .deact_len_in  (deactivate_len),
      .act_hit_out   (act_hit[ch]),
      .deact_hit_out (deact_hit[ch])
    );
  end

  // Status follows hits; an activate hit wins a same-cycle tie
  always_comb begin
    loop_detect_state_nxt = loop_detect_state_r;
    for (int ch = 0; ch < NCH; ch++) begin
      if (detector_global_enable && act_hit[ch]) begin
        loop_detect_state_nxt[ch] = 1'b1;
      end else if (detector_global_enable && deact_hit[ch]) begin
        loop_detect_state_nxt[ch] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      loop_detect_state_r <= ilb_pkg::RST_BYTE;
    end else begin
      loop_detect_state_r <= loop_detect_state_nxt;
    end
  end

  assign irq_set = (loop_detect_state_nxt ^ loop_detect_state_r)
                   & loop_irq_mask_r & {NCH{detector_global_enable}};

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      loop_irq_flag_r <= ilb_pkg::RST_BYTE;
    end else begin
      loop_irq_flag_r <= (loop_irq_flag_r & ~{NCH{status_read}}) | irq_set;
    end
  end

  // Automatic loopback request per channel
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      loop_active_out <= ilb_pkg::RST_BYTE;
    end else begin
      loop_active_out <= loop_detect_state_r & {NCH{auto_loop_enable}};
    end
  end

  // Code generators, one per transmitter
  for (genvar ch = 0; ch < NCH; ch++) begin : g_gen
    logic [3:0] gen_ptr_r;
    logic [7:0] gen_code;
    logic [3:0] gen_len;

    assign gen_code = generator_code_choice_r[ch] ? deactivate_code_r : activate_code_r;
    assign gen_len  = generator_code_choice_r[ch] ? deactivate_len : activate_len;

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
        gen_ptr_r       <= 4'h0;
        tx_data_out[ch] <= 1'b0;
      end else if (!generator_on_r[ch]) begin
        gen_ptr_r <= 4'h0;
        if (tx_bit_valid_in[ch]) begin
          tx_data_out[ch] <= tx_data_in[ch];
        end
      end else if (tx_bit_valid_in[ch]) begin
        tx_data_out[ch] <= gen_code[3'h7 - gen_ptr_r[2:0]];
        if (gen_ptr_r >= gen_len - 4'h1) begin
          gen_ptr_r <= 4'h0;
        end else begin
          gen_ptr_r <= gen_ptr_r + 4'h1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ===== logic/ilb_pkg.sv
// Shared constants for the inband loopback code register bank
`default_nettype none
package ilb_pkg;

  localparam int          NUM_CH           = 8;
  localparam int          DETECT_BITS_DFLT = 1024;

  // Register offsets in the expanded bank
  localparam logic [7:0]  OFS_CONFIG       = 8'h08;
  localparam logic [7:0]  OFS_ACT_CODE     = 8'h09;
  localparam logic [7:0]  OFS_DEACT_CODE   = 8'h0A;
  localparam logic [7:0]  OFS_RX_STATUS    = 8'h0B;
  localparam logic [7:0]  OFS_IRQ_MASK     = 8'h0C;
  localparam logic [7:0]  OFS_IRQ_STATUS   = 8'h0D;
  localparam logic [7:0]  OFS_GEN_SELECT   = 8'h0E;
  localparam logic [7:0]  OFS_GEN_ENABLE   = 8'h0F;

  localparam logic [7:0]  RST_BYTE         = 8'h00;
  localparam logic [7:0]  READ_UNMAPPED    = 8'h00;

  // Configuration register fields
  localparam int          CFG_DET_EN_BIT   = 5;
  localparam int          CFG_AUTO_BIT     = 4;
  localparam int          CFG_ALEN_LSB     = 2;
  localparam int          CFG_DLEN_LSB     = 0;

  localparam logic [3:0]  MIN_CODE_LEN     = 4'h5;

  // Length select 00..11 gives 5..8 effective upper bits
  function automatic logic [3:0] code_len(input logic [1:0] sel);
    return MIN_CODE_LEN + {2'h0, sel};
  endfunction

endpackage
`default_nettype wire

// ===== logic/ilb_detector.sv
// Per-channel repeating loopback code detector
`timescale 1ns/1ns
`default_nettype none
module ilb_detector #(
  parameter int DETECT_BITS = ilb_pkg::DETECT_BITS_DFLT
) (
  input  wire logic       ref_clk_in,
  input  wire logic       reset_in,
  input  wire logic       bit_valid_in,
  input  wire logic       bit_in,
  input  wire logic       det_enable_in,
  input  wire logic [7:0] act_code_in,
  input  wire logic [3:0] act_len_in,
  input  wire logic [7:0] deact_code_in,
  input  wire logic [3:0] deact_len_in,
  output logic            act_hit_out,
  output logic            deact_hit_out
);

  localparam int CW = $clog2(DETECT_BITS + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DETECT_BITS);

  generate
    if (DETECT_BITS < 1) begin : g_bad
      $error("DETECT_BITS must be at least 1");
    end
  endgenerate

  logic [7:0]    hist_r;
  logic [CW-1:0] act_cnt_r;
  logic [CW-1:0] deact_cnt_r;
  logic [7:0]    hist_nxt;
  logic          act_match;
  logic          deact_match;

  // True when the newest bits form some rotation of the upper len bits of code
  // and the whole window repeats with period len
  function automatic logic rot_match(input logic [7:0] h, input logic [7:0] code,
                                     input logic [3:0] len);
    logic any_rot;
    logic ok;
    int   idx;
    any_rot = 1'b0;
    for (int r = 0; r < 8; r++) begin
      ok = (r < int'(len));
      for (int j = 0; j < 8; j++) begin
        if (j < int'(len)) begin
          idx = (r + int'(len) - j) % int'(len);
          if (h[j] != code[7 - idx]) begin
            ok = 1'b0;
          end
        end
      end
      any_rot = any_rot | ok;
    end
    for (int j = 0; j < 8; j++) begin
      if (j + int'(len) < 8 && h[j] != h[j + int'(len)]) begin
        any_rot = 1'b0;
      end
    end
    return any_rot;
  endfunction

  assign hist_nxt    = {hist_r[6:0], bit_in};
  assign act_match   = rot_match(hist_nxt, act_code_in, act_len_in);
  assign deact_match = rot_match(hist_nxt, deact_code_in, deact_len_in);

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      hist_r <= 8'h00;
    end else if (bit_valid_in) begin
      hist_r <= hist_nxt;
    end
  end

  // Match must hold for DETECT_BITS consecutive bits before a hit
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      act_cnt_r   <= '0;
      act_hit_out <= 1'b0;
    end else begin
      act_hit_out <= 1'b0;
      if (!det_enable_in) begin
        act_cnt_r <= '0;
      end else if (bit_valid_in) begin
        if (!act_match) begin
          act_cnt_r <= '0;
        end else if (act_cnt_r != CNT_FULL) begin
          act_cnt_r   <= act_cnt_r + CW'(1);
          act_hit_out <= (act_cnt_r == CNT_FULL - CW'(1));
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      deact_cnt_r   <= '0;
      deact_hit_out <= 1'b0;
    end else begin
      deact_hit_out <= 1'b0;
      if (!det_enable_in) begin
        deact_cnt_r <= '0;
      end else if (bit_valid_in) begin
        if (!deact_match) begin
          deact_cnt_r <= '0;
        end else if (deact_cnt_r != CNT_FULL) begin
          deact_cnt_r   <= deact_cnt_r + CW'(1);
          deact_hit_out <= (deact_cnt_r == CNT_FULL - CW'(1));
        end
      end
    end
  end

endmodule
`default_nettype wire

// ===== tb/ilb_far_end.sv
// Remote line end that repeats a loopback code on chosen receive channels
`timescale 1ns/1ns
`default_nettype none
module ilb_far_end (
  input  wire logic       clk_in,
  input  wire logic [7:0] run_in,
  input  wire logic [7:0] code_in,
  input  wire logic [3:0] len_in,
  output logic      [7:0] valid_out,
  output logic      [7:0] data_out
);
  logic [3:0] pos_r;
  logic       ph_r;
  initial begin
    pos_r = 4'h0;
    ph_r = 1'b0;
    valid_out = 8'h00;
    data_out = 8'h00;
  end
  // Code sent MSB first, one bit every other cycle; idle lines toggle
  // Driven on the falling edge so the receiver samples settled bits
  always @(negedge clk_in) begin
    ph_r <= ~ph_r;
    if (run_in != 8'h00 && ph_r) begin
      valid_out <= run_in;
      data_out <= (run_in & {8{code_in[4'h7 - pos_r]}}) | (~run_in & ~data_out);
      pos_r <= (pos_r + 4'h1 == len_in) ? 4'h0 : pos_r + 4'h1;
    end else begin
      valid_out <= 8'h00;
      data_out <= ~data_out;
      if (run_in == 8'h00) begin
        pos_r <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/ilb_regs_chk.sv
// Port-level assertions for the loopback register bank
`timescale 1ns/1ns
`default_nettype none
module ilb_regs_chk #(
  parameter int DETECT_BITS = 1024
) (
  input  wire logic       ref_clk_in,
  input  wire logic       reset_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic [7:0] reg_rdata_out,
  input  wire logic [7:0] rx_bit_valid_in,
  input  wire logic [7:0] rx_data_in,
  input  wire logic [7:0] tx_bit_valid_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic [7:0] tx_data_out,
  input  wire logic [7:0] loop_active_out
);
  logic [7:0] cfg_r, act_r, dct_r, msk_r, sel_r, gen_r, new_r, allow_r, top_w;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  assign top_w = (sel_r & {8{dct_r[7]}}) | (~sel_r & {8{act_r[7]}});
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      {cfg_r, act_r, dct_r, msk_r, sel_r, gen_r} <= '0;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        8'h08: cfg_r <= reg_wdata_in;
        8'h09: act_r <= reg_wdata_in;
        8'h0A: dct_r <= reg_wdata_in;
        8'h0C: msk_r <= reg_wdata_in;
        8'h0E: sel_r <= reg_wdata_in;
        8'h0F: gen_r <= reg_wdata_in;
        default: ;
      endcase
    end
  end
  // Generators switched on and not yet strobed
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      new_r <= 8'h00;
    end else begin
      new_r <= (new_r & ~tx_bit_valid_in)
             | ((reg_wr_in && reg_addr_in == 8'h0F) ? reg_wdata_in & ~gen_r : 8'h00);
    end
  end
  // Channels that could have raised a flag since the last status read
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      allow_r <= 8'h00;
    end else begin
      allow_r <= ((reg_rd_in && reg_addr_in == 8'h0B) ? 8'h00 : allow_r)
               | (msk_r & {8{cfg_r[5]}});
    end
  end
  sequence s_rd(logic [7:0] a);
    reg_rd_in && reg_addr_in == a;
  endsequence
  a_act_readback: assert property (s_rd(8'h09) |=> reg_rdata_out == $past(act_r))
    else $error("activate code readback wrong");
  a_mask_readback: assert property (s_rd(8'h0C) |=> reg_rdata_out == $past(msk_r))
    else $error("mask readback wrong");
  a_sel_readback: assert property (s_rd(8'h0E) |=> reg_rdata_out == $past(sel_r))
    else $error("select readback wrong");
  a_gen_readback: assert property (s_rd(8'h0F) |=> reg_rdata_out == $past(gen_r))
    else $error("enable readback wrong");
  a_irq_masked: assert property (s_rd(8'h0D) |=> (reg_rdata_out & ~allow_r) == 8'h00)
    else $error("flag set on blocked channel");
  a_tx_passthru: assert property ((tx_bit_valid_in & ~gen_r) != 8'h00 |=>
    ((tx_data_out ^ $past(tx_data_in)) & $past(tx_bit_valid_in & ~gen_r)) == 8'h00)
    else $error("transmit data not passed through");
  a_tx_holds: assert property (tx_bit_valid_in != 8'hFF |=>
    ((tx_data_out ^ $past(tx_data_out)) & ~$past(tx_bit_valid_in)) == 8'h00)
    else $error("transmit bit moved without strobe");
  a_gen_first_bit: assert property ((tx_bit_valid_in & gen_r & new_r) != 8'h00 |=>
    ((tx_data_out ^ $past(top_w)) & $past(tx_bit_valid_in & gen_r & new_r)) == 8'h00)
    else $error("generator did not start at top code bit");
  a_auto_gates_loop: assert property (!cfg_r[4] [*2] |-> loop_active_out == 8'h00)
    else $error("loopback active with auto disabled");
endmodule
`default_nettype wire

// ===== tb/tb_ilb_regs.sv
// Self-checking bench for the loopback register bank
`timescale 1ns/1ns
`default_nettype none
module tb_ilb_regs;
  logic       ref_clk_in, reset_in, wr, rd;
  logic [7:0] addr, wdat, rdat, rx_v, rx_d, tx_v, tx_d, tx_o, loop_o, run, code;
  logic [7:0] act_c, dct_c;
  logic [3:0] len;
  int         n_fail, tests_run;
  ilb_regs #(.DETECT_BITS(16)) DUT (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdat),
    .reg_rdata_out(rdat), .rx_bit_valid_in(rx_v), .rx_data_in(rx_d), .tx_bit_valid_in(tx_v),
    .tx_data_in(tx_d), .tx_data_out(tx_o), .loop_active_out(loop_o));
  ilb_far_end u_far (.clk_in(ref_clk_in), .run_in(run), .code_in(code), .len_in(len),
    .valid_out(rx_v), .data_out(rx_d));
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  task automatic conclude();
    $display("comparisons=%0d mismatches=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    addr = a;
    wdat = d;
    wr = 1'b1;
    @(negedge ref_clk_in);
    wr = 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge ref_clk_in);
    addr = a;
    rd = 1'b1;
    @(negedge ref_clk_in);
    rd = 1'b0;
    chk(rdat, exp);
  endtask
  task automatic send(input logic [7:0] ch, input logic [7:0] c, input logic [3:0] l);
    @(negedge ref_clk_in);
    run = ch;
    code = c;
    len = l;
    repeat (120) @(negedge ref_clk_in);
    run = 8'h00;
    repeat (6) @(negedge ref_clk_in);
  endtask
  task automatic wait_loop(input logic [7:0] exp);
    int k;
    k = 0;
    while (loop_o !== exp && k < 200) begin
      @(negedge ref_clk_in);
      k++;
    end
    chk(loop_o, exp);
    if (k == 200) conclude();
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    n_fail++;
    conclude();
  end
  initial begin
    {reset_in, wr, rd, addr, wdat, tx_v, tx_d, run, code} = {1'b1, 50'h0};
    {len, n_fail, tests_run} = {4'h8, 64'h0};
    act_c = 8'hC6;
    dct_c = 8'hA5;
    repeat (2) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    reset_in = 1'b0;
    for (int a = 8; a < 17; a++) rchk(8'(a), 8'h00);
    wreg(8'h0B, 8'hFF);
    wreg(8'h0D, 8'hFF);
    rchk(8'h0B, 8'h00);
    rchk(8'h0D, 8'h00);
    wreg(8'h08, 8'h02);
    wreg(8'h09, act_c);
    wreg(8'h0A, dct_c);
    wreg(8'h0E, 8'h02);
    wreg(8'h0F, 8'h03);
    rchk(8'h09, act_c);
    rchk(8'h0E, 8'h02);
    for (int i = 0; i < 16; i++) begin
      @(negedge ref_clk_in);
      tx_v = 8'h07;
      tx_d = {8{i[0]}};
      @(negedge ref_clk_in);
      tx_v = 8'h00;
      chk(tx_o & 8'h07, {5'h00, i[0], dct_c[7 - i % 7], act_c[7 - i % 5]});
    end
    wreg(8'h0F, 8'h00);
    wreg(8'h09, 8'hB6);
    wreg(8'h0C, 8'h01);
    wreg(8'h08, 8'h17);
    send(8'h02, 8'hB6, 4'h3);
    rchk(8'h0B, 8'h00);
    wreg(8'h08, 8'h37);
    send(8'h03, 8'hB6, 4'h3);
    wait_loop(8'h03);
    rchk(8'h0D, 8'h01);
    rchk(8'h0B, 8'h03);
    rchk(8'h0D, 8'h00);
    send(8'h01, dct_c, 4'h8);
    wait_loop(8'h02);
    rchk(8'h0D, 8'h01);
    rchk(8'h0B, 8'h02);
    wreg(8'h08, 8'h27);
    wait_loop(8'h00);
    wreg(8'h0A, 8'h99);
    send(8'h02, 8'h99, 4'h4);
    rchk(8'h0D, 8'h00);
    rchk(8'h0B, 8'h00);
    conclude();
  end
endmodule
bind ilb_regs ilb_regs_chk #(.DETECT_BITS(DETECT_BITS)) u_chk (.ref_clk_in(ref_clk_in),
  .reset_in(reset_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .rx_bit_valid_in(rx_bit_valid_in), .rx_data_in(rx_data_in),
  .tx_bit_valid_in(tx_bit_valid_in), .tx_data_in(tx_data_in), .tx_data_out(tx_data_out),
  .loop_active_out(loop_active_out));
`default_nettype wire
